// >>> logic/csol_fifo.sv
`timescale 1ns/100ps
module csol_fifo
  import csol_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             do_wr;
  logic             do_rd;

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      // Ready is registered so that it leaves the block from a flip-flop.
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

// >>> logic/csol_strap_logic.sv
`timescale 1ns/100ps
// Function
// RULE1 - Both rate straps open: 10/15/30 cps
// RULE2 - Mid strap, middle selector: 120 cps
// RULE3 - Low strap, bottom selector: 120 cps
// RULE4 - Delay strap fitted: 450 ms after codes
// RULE5 - Delay strap removed: no code pauses
// RULE6 - Second board, echo open: echo tape DC3
// RULE7 - Second board, entry open: DC2 writes gap
// RULE8 - Third board timer: 300 or 430 ms
// RULE9 - Third board read-delay strap skips online delays
// RULE10 - Third board gap open: no DC2 gap
// RULE11 - Third board stop-read open: halt before DC3
// RULE12 - Terminal treats DC3 as reader off
// RULE13 - Straps are static, sampled continuously
module csol_strap_logic
  import csol_pkg::*;
#(
  parameter int DELAY_CYCLES = DELAY_CYC,
  parameter int TIMER_SHORT  = TIMER_SHORT_CYC,
  parameter int TIMER_LONG   = TIMER_LONG_CYC,
  parameter int FIFO_DEPTH   = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] board_variant,
  input  wire logic       delay_strap,
  input  wire logic       rate_mid_or_timer_strap,
  input  wire logic       rate_low_or_read_delay_strap,
  input  wire logic       echo_or_gap_strap,
  input  wire logic       write_entry_or_stop_read_strap,
  input  wire logic [1:0] rate_selector,
  input  wire logic [1:0] terminal_mode,
  input  wire logic [7:0] tape_data,
  input  wire logic       tape_valid,
  output logic            tape_ready,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       timer_start,
  output logic [7:0]      char_data,
  output logic            char_valid,
  input  wire logic       char_ready,
  output logic [7:0]      rate_cps,
  output logic            write_mode,
  output logic            gap_pulse,
  output logic            read_halt,
  output logic            timer_busy
);
  // Straps and selector come from pins: two-flop synchronisers.
  localparam int SW = 11;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {board_variant, delay_strap, rate_mid_or_timer_strap,
                rate_low_or_read_delay_strap, echo_or_gap_strap,
                write_entry_or_stop_read_strap, rate_selector,
                terminal_mode};
      sync2 <= sync1; // see RULE13
    end
  end
  logic [1:0] s_var;
  logic       s_dly;
  logic       s_j2;
  logic       s_j3;
  logic       s_j4;
  logic       s_j5;
  logic [1:0] s_sel;
  logic [1:0] s_mode;
  assign {s_var, s_dly, s_j2, s_j3, s_j4, s_j5, s_sel, s_mode} = sync2;

  logic [7:0] f_data;
  logic       f_valid;
  logic       f_ready;
  csol_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (tape_data),
    .in_valid  (tape_valid),
    .in_ready  (tape_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  typedef struct packed {
    csol_state_e st;
    logic [31:0] cnt;
    logic        esc_seen;
    logic [31:0] tmr;
    logic [7:0]  data;
    logic        valid;
    logic [7:0]  rate;
    logic        wmode;
    logic        gap;
    logic        halt;
    logic        busy;
  } csol_state_s;

  csol_state_s r;
  csol_state_s next_r;

  logic is_dcode;
  logic pause_ok;
  logic third;
  logic second;
  logic fast;

  always_comb begin
    third = (s_var == VAR_THIRD);
    second = (s_var == VAR_SECOND);
    fast = (!third && s_j2 && !s_j3 && s_sel == SEL_MIDDLE) || // see RULE2
           (!third && s_j3 && !s_j2 && s_sel == SEL_BOTTOM);   // see RULE3
    is_dcode = (f_data == CH_LF) || (f_data == CH_BS) ||
               (f_data == CH_VT) || (f_data == CH_FF) ||
               (r.esc_seen && (f_data == CH_H || f_data == CH_J));
    pause_ok = s_dly && // see RULE5
               !(third && s_j3 && s_mode != MODE_LOCAL); // see RULE9
    f_ready = (r.st == CSOL_IDLE);
    next_r = r;
    next_r.gap = 1'b0;
    // Rate code: fast, else the normal selector rates.
    if (fast) begin
      next_r.rate = 8'(RATE_FAST_CPS);
    end else if (s_sel == SEL_BOTTOM) begin
      next_r.rate = 8'(RATE_LOW_CPS); // see RULE1
    end else if (s_sel == SEL_MIDDLE) begin
      next_r.rate = 8'(RATE_MID_CPS); // see RULE1
    end else begin
      next_r.rate = 8'(RATE_HIGH_CPS); // see RULE1
    end
    // Received DC2 handling; DC3 is the terminal's reader-off.
    if (rx_valid && rx_data == CH_DC2) begin
      if (second && !s_j5) begin
        next_r.wmode = 1'b1; // see RULE7
        next_r.gap = 1'b1;   // see RULE7
      end else if (third) begin
        next_r.wmode = 1'b1;
        next_r.gap = s_j4;   // see RULE10
      end
    end else if (rx_valid && rx_data == CH_DC3) begin
      next_r.wmode = 1'b0; // see RULE12
    end
    // Interface timer.
    if (timer_start) begin
      next_r.tmr = s_j2 ? 32'(TIMER_SHORT) : 32'(TIMER_LONG); // see RULE8
      next_r.busy = third;
    end else if (r.tmr != CNT_RESET) begin
      // Only the third board shows the timer as busy.
      next_r.tmr = r.tmr - 32'h0000_0001;
      next_r.busy = third && (r.tmr != 32'h0000_0001);
    end
    case (r.st)
      CSOL_IDLE: begin
        if (f_valid) begin
          next_r.esc_seen = (f_data == CH_ESC);
          if (f_data == CH_DC3 && third && !s_j5) begin
            next_r.halt = 1'b1; // see RULE11
          end
          if (f_data == CH_DC3 && second && s_j4) begin
            next_r.st = CSOL_IDLE; // Echo strap fitted: DC3 is dropped.
          end else begin
            next_r.data = f_data; // see RULE6
            next_r.valid = 1'b1;
            next_r.st = CSOL_SEND;
            next_r.cnt = (is_dcode && pause_ok) ? // see RULE4
                         32'(DELAY_CYCLES) : CNT_RESET;
          end
        end
      end
      CSOL_SEND: begin
        if (char_ready) begin
          next_r.valid = 1'b0;
          next_r.halt = 1'b0;
          next_r.st = (r.cnt != CNT_RESET) ? CSOL_PAUSE : CSOL_IDLE;
        end
      end
      CSOL_PAUSE: begin
        next_r.cnt = r.cnt - 32'h0000_0001;
        if (r.cnt == 32'h0000_0001) begin
          next_r.st = CSOL_IDLE;
        end
      end
      default: begin
        next_r.st = CSOL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: CSOL_IDLE, rate: 8'(RATE_HIGH_CPS), default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign char_data = r.data;
  assign char_valid = r.valid;
  assign rate_cps = r.rate;
  assign write_mode = r.wmode;
  assign gap_pulse = r.gap;
  assign read_halt = r.halt;
  assign timer_busy = r.busy;

  property p_pause_len;
    @(posedge clk) disable iff (!rst_n)
      (r.st == CSOL_SEND && char_ready && r.cnt != CNT_RESET)
      |=> (r.st == CSOL_PAUSE);
  endproperty
  a_pause_len: assert property (p_pause_len) // see RULE4
    else $error("delay code did not pause");

  property p_no_pause;
    @(posedge clk) disable iff (!rst_n)
      (r.st == CSOL_IDLE && f_valid && !s_dly) |=> (r.cnt == CNT_RESET);
  endproperty
  a_no_pause: assert property (p_no_pause) // see RULE5
    else $error("pause without delay strap");

  property p_gap2;
    @(posedge clk) disable iff (!rst_n)
      (rx_valid && rx_data == CH_DC2 && second && !s_j5)
      |=> (gap_pulse && write_mode);
  endproperty
  a_gap2: assert property (p_gap2) // see RULE7
    else $error("DC2 did not start write and gap");

  property p_gap3;
    @(posedge clk) disable iff (!rst_n)
      (rx_valid && rx_data == CH_DC2 && third && !s_j4) |=> !gap_pulse;
  endproperty
  a_gap3: assert property (p_gap3) // see RULE10
    else $error("gap written with gap strap open");

  property p_timer;
    @(posedge clk) disable iff (!rst_n)
      (timer_start && third) |=> (r.tmr == (s_j2 ? 32'(TIMER_SHORT)
                                            : 32'(TIMER_LONG)));
  endproperty
  a_timer: assert property (p_timer) // see RULE8
    else $error("timer period wrong");

  property p_fast;
    @(posedge clk) disable iff (!rst_n)
      (fast && !timer_start) |=> (rate_cps == 8'(RATE_FAST_CPS));
  endproperty
  a_fast: assert property (p_fast) // see RULE2
    else $error("fast rate not selected");

  property p_halt;
    @(posedge clk) disable iff (!rst_n)
      (r.st == CSOL_IDLE && f_valid && f_data == CH_DC3 && third && !s_j5)
      |=> (read_halt && char_valid);
  endproperty
  a_halt: assert property (p_halt) // see RULE11
    else $error("no halt before DC3");

  property p_echo;
    @(posedge clk) disable iff (!rst_n)
      (r.st == CSOL_IDLE && f_valid && f_data == CH_DC3 && second && !s_j4)
      |=> (char_valid && char_data == CH_DC3);
  endproperty
  a_echo: assert property (p_echo) // see RULE6
    else $error("DC3 not echoed");
endmodule

// >>> shared/csol_pkg.sv
package csol_pkg;

  localparam int CLK_HZ = 125_000_000;

  // Pause after a delay code.
  localparam int DELAY_MS = 450;
  localparam int DELAY_CYC = (DELAY_MS * (CLK_HZ / 1000));

  // Interface timer periods.
  localparam int TIMER_SHORT_MS = 300;
  localparam int TIMER_LONG_MS = 430;
  localparam int TIMER_SHORT_CYC = (TIMER_SHORT_MS * (CLK_HZ / 1000));
  localparam int TIMER_LONG_CYC = (TIMER_LONG_MS * (CLK_HZ / 1000));

  // Character rates in characters per second.
  localparam int RATE_LOW_CPS = 10;
  localparam int RATE_MID_CPS = 15;
  localparam int RATE_HIGH_CPS = 30;
  localparam int RATE_FAST_CPS = 120;

  // Rate selector positions from the terminal.
  localparam logic [1:0] SEL_TOP = 2'h0;
  localparam logic [1:0] SEL_MIDDLE = 2'h1;
  localparam logic [1:0] SEL_BOTTOM = 2'h2;

  // Board variants.
  localparam logic [1:0] VAR_FIRST = 2'h0;
  localparam logic [1:0] VAR_SECOND = 2'h1;
  localparam logic [1:0] VAR_THIRD = 2'h2;

  // Terminal modes.
  localparam logic [1:0] MODE_LOCAL = 2'h0;
  localparam logic [1:0] MODE_ONLINE = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;

  // Character codes.
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_VT = 8'h0b;
  localparam logic [7:0] CH_FF = 8'h0c;
  localparam logic [7:0] CH_DC2 = 8'h12;
  localparam logic [7:0] CH_DC3 = 8'h13;
  localparam logic [7:0] CH_ESC = 8'h1b;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_J = 8'h4a;

  localparam logic [31:0] CNT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    CSOL_IDLE  = 2'b00,
    CSOL_SEND  = 2'b01,
    CSOL_PAUSE = 2'b10
  } csol_state_e;

endpackage

// >>> tb/cassette_strap_option_logic_test.sv
`timescale 1ns/100ps
module cassette_strap_option_logic_test;
  import csol_pkg::*;
  logic       clk, rst_n, tape_valid, tape_ready, rx_valid, timer_start;
  logic       char_valid, char_ready, write_mode, gap_pulse, read_halt;
  logic       timer_busy, stall, reader_off;
  logic       prev_dc3 = 1'b0;
  logic [1:0] v, sel, md;
  logic [4:0] s;
  logic [7:0] tape_data, rx_data, char_data, rate_cps;
  int         n_mismatch, comparisons, cyc, last_acc, gap, n, t;
  logic [7:0] exp_q[$];
  logic [8:0] dcfg[5] = '{9'h040, 9'h000, 9'h151, 9'h150, 9'h152};
  logic [6:0] ec[7] = '{7'h22, 7'h20, 7'h40, 7'h41, 7'h42, 7'h21, 7'h00};
  logic [6:0] tc[3] = '{7'h48, 7'h40, 7'h08};
  logic [15:0] dc[6] = '{{8'h00, CH_BS}, {8'h00, CH_LF}, {8'h00, CH_VT},
                         {8'h00, CH_FF}, {CH_ESC, CH_H}, {CH_ESC, CH_J}};

  csol_strap_logic #(.DELAY_CYCLES(20), .TIMER_SHORT(10), .TIMER_LONG(15))
  DUT (.clk(clk), .rst_n(rst_n), .board_variant(v), .delay_strap(s[4]),
    .rate_mid_or_timer_strap(s[3]), .rate_low_or_read_delay_strap(s[2]),
    .echo_or_gap_strap(s[1]), .write_entry_or_stop_read_strap(s[0]),
    .rate_selector(sel), .terminal_mode(md), .tape_data(tape_data),
    .tape_valid(tape_valid), .tape_ready(tape_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .timer_start(timer_start), .char_data(char_data),
    .char_valid(char_valid), .char_ready(char_ready), .rate_cps(rate_cps),
    .write_mode(write_mode), .gap_pulse(gap_pulse), .read_halt(read_halt),
    .timer_busy(timer_busy));

  csol_term_model TERM (.clk(clk), .rst_n(rst_n), .char_valid(char_valid),
    .char_data(char_data), .stall(stall), .char_ready(char_ready),
    .reader_off(reader_off));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_rate();
    if (v != VAR_THIRD && s[3] && !s[2] && sel == SEL_MIDDLE) return 8'd120;
    if (v != VAR_THIRD && s[2] && !s[3] && sel == SEL_BOTTOM) return 8'd120;
    return (sel == SEL_TOP) ? 8'd30 : (sel == SEL_MIDDLE) ? 8'd15 : 8'd10;
  endfunction

  // Settles the straps; they pass two sync flops before taking effect.
  task automatic cfg(input logic [1:0] nv, input logic [4:0] ns,
                     input logic [1:0] nsel, input logic [1:0] nmd);
    @(negedge clk);
    v = nv;
    s = ns;
    sel = nsel;
    md = nmd;
    repeat (4) @(negedge clk);
  endtask

  // Called at a falling edge; returns at the falling edge after the take.
  task automatic push(input logic [7:0] b);
    tape_data = b;
    tape_valid = 1'b1;
    if (!(b == CH_DC3 && v == VAR_SECOND && s[1])) exp_q.push_back(b);
    while (!tape_ready) @(negedge clk);
    @(negedge clk);
  endtask

  task automatic drain;
    tape_valid = 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(exp_q.size(), 0);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (rst_n && char_valid && char_ready) begin
      gap = cyc - last_acc;
      last_acc = cyc;
      if (exp_q.size() == 0) chk(char_data, 8'hff);
      else chk(char_data, exp_q.pop_front());
      if (char_data == CH_DC3) begin
        chk(read_halt, v == VAR_THIRD && !s[0]);
      end
      chk(reader_off, prev_dc3);
      prev_dc3 = (char_data == CH_DC3);
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(8 * 80000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {rst_n, tape_valid, rx_valid, timer_start, stall} = 5'h00;
    {v, s, sel, md, tape_data, rx_data} = 27'h000_0000;
    void'($urandom(11761));
    repeat (8) @(negedge clk);
    chk(rate_cps, 8'd30);
    rst_n = 1'b1;
    for (int i = 0; i < 27; i++) begin
      cfg(i / 9, (i / 3 % 3 == 0) ? 5'h00 : (i / 3 % 3 == 1) ? 5'h08 : 5'h04,
          i % 3, MODE_LOCAL);
      chk(rate_cps, exp_rate());
    end
    for (int k = 0; k < 5; k++) begin
      cfg(dcfg[k][8:7], dcfg[k][6:2], SEL_TOP, dcfg[k][1:0]);
      for (int j = 0; j < 6; j++) begin
        if (dc[j][15:8] != 8'h00) push(dc[j][15:8]);
        push(dc[j][7:0]);
        push(8'h20 + 8'($urandom % 90));
        drain();
        t = s[4] && !(v == VAR_THIRD && s[2] && md != MODE_LOCAL);
        chk(gap >= 20, t);
      end
    end
    for (int k = 0; k < 7; k++) begin
      cfg(ec[k][6:5], ec[k][4:0], SEL_TOP, MODE_LOCAL);
      push(CH_DC3);
      push(8'h41);
      drain();
      rx_data = CH_DC2;
      rx_valid = 1'b1;
      n = 0;
      repeat (4) begin
        @(negedge clk);
        rx_valid = 1'b0;
        n += gap_pulse;
      end
      t = v == VAR_SECOND ? !s[0] : v == VAR_THIRD ? s[1] : 0;
      chk(n, t);
      t = v == VAR_SECOND ? !s[0] : v == VAR_THIRD;
      chk(write_mode, t);
      rx_data = CH_DC3;
      rx_valid = 1'b1;
      repeat (3) begin
        @(negedge clk);
        rx_valid = 1'b0;
      end
      chk(write_mode, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      cfg(tc[k][6:5], tc[k][4:0], SEL_TOP, MODE_LOCAL);
      timer_start = 1'b1;
      n = 0;
      repeat (40) begin
        @(negedge clk);
        timer_start = 1'b0;
        n += timer_busy;
      end
      t = s[3] ? 10 : 15;
      if (v != VAR_THIRD) t = 0;
      chk(n, t);
    end
    cfg(VAR_FIRST, 5'h00, SEL_TOP, MODE_LOCAL);
    stall = 1'b1;
    repeat (4) @(negedge clk);
    tape_valid = 1'b1;
    for (n = 0; tape_ready && n < 20; n++) begin
      tape_data = 8'($urandom % 256) | 8'h40;
      exp_q.push_back(tape_data);
      @(negedge clk);
    end
    tape_valid = 1'b0;
    chk(tape_ready, 1'b0);
    chk(n >= 8, 1);
    stall = 1'b0;
    drain();
    complete_run();
  end
endmodule

// >>> tb/csol_term_model.sv
`timescale 1ns/100ps
module csol_term_model
  import csol_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       char_valid,
  input  wire logic [7:0] char_data,
  input  wire logic       stall,
  output logic            char_ready,
  output logic            reader_off
);
  // The terminal takes characters at an uneven pace and may stall.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      char_ready <= 1'b0;
      reader_off <= 1'b0;
    end else begin
      char_ready <= !stall && ($urandom % 4 != 0);
      if (char_valid && char_ready) begin
        reader_off <= (char_data == CH_DC3);
      end
    end
  end
endmodule
